// ### pkg/mbrs_pkg.sv
package mbrs_pkg;
  // timing
  localparam int CLK_HZ = 200_000_000;
  localparam int BAUD = 9600;
  localparam int BIT_CYC = CLK_HZ / BAUD;
  localparam int GAP_CHAR_MS = 15;
  localparam int GAP_FRAME_MS = 35;
  localparam int GAP_CHAR_CYC = GAP_CHAR_MS * (CLK_HZ / 1000);
  localparam int GAP_FRAME_CYC = GAP_FRAME_MS * (CLK_HZ / 1000);
  // station address
  localparam logic [7:0] ST_RST = 8'h01;
  localparam logic [7:0] ST_MIN = 8'h01;
  localparam logic [7:0] ST_MAX = 8'hdf;
  // function and exception codes
  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_RD_IN = 8'h04;
  localparam logic [7:0] FC_WR_ONE = 8'h06;
  localparam logic [7:0] FC_WR_MANY = 8'h10;
  localparam logic [7:0] FC_EXC = 8'h80;
  localparam logic [7:0] EX_NONE = 8'h00;
  localparam logic [7:0] EX_FUNC = 8'h01;
  localparam logic [7:0] EX_ADDR = 8'h02;
  localparam logic [7:0] EX_VAL = 8'h03;
  localparam logic [15:0] MAX_RD = 16'h007d;
  localparam logic [15:0] UNDEF_VAL = 16'hffff;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  // storage and frame sizes
  localparam int NREG = 8;
  localparam int AW = $clog2(NREG);
  localparam int NBLK = 4;
  localparam int RXB = 24;
  localparam logic [15:0] REG_RST = 16'h0000;

  typedef struct packed {
    logic [15:0] base;
    logic [15:0] size;
    logic na;
    logic [15:0] fill;
  } mbrs_blk_t;

  localparam mbrs_blk_t BLK_MAP [NBLK] = '{
    '{16'h0000, 16'h0004, 1'b0, 16'h0000},
    '{16'h0004, 16'h0002, 1'b0, 16'h0000},
    '{16'h0006, 16'h0001, 1'b0, 16'h0000},
    '{16'h0007, 16'h0001, 1'b1, 16'h0000}
  };

  typedef struct packed {
    logic vld;
    logic err;
    logic [7:0] data;
  } mbrs_byte_t;

  typedef enum logic [3:0] {
    S_RX = 4'b0001,
    S_CHK = 4'b0010,
    S_TX = 4'b0100,
    S_SYNC = 4'b1000
  } mbrs_state_t;

  function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

// ### src/mbrs_slave.sv
// Operation
// - link runs 9600 baud, 8 data bits, no parity, one stop bit, binary
// - reads must start and end on block edges, else illegal data address
// - a read covering several whole blocks returns all of them at once
// - a write must hit exactly one whole block, else illegal data address
// - reading an undefined register is accepted and returns 0xffff
// - fc 3 and 4 reads give 0xffff at every undefined position
// - any write touching an undefined register gets illegal data address
// - a defined but absent register reads as its own fill value
// - writing a defined but absent register gets illegal data address
// - station address resets to 1, settable only within 1 to 223
// - station addresses 224 to 247 are never accepted
// - single-register write answer carries the value stored after the write
// - only binary framing; character-based frames are not decoded
// - a frame ends only after at least 15 ms of idle line
// - after a receive error the receiver waits 35 ms idle to resync
// - reads use fc 3 or 4, single writes fc 6, multi writes fc 16
// - wide values go most significant word at the lowest register
// - text byte order is high byte then low byte of each register
module mbrs_slave
  import mbrs_pkg::*;
#(
  parameter int BIT_CYC_P = BIT_CYC,
  parameter int GAP_CHAR_P = GAP_CHAR_CYC,
  parameter int GAP_FRAME_P = GAP_FRAME_CYC
) (
  // clock, reset, enable
  input logic core_clk_i,
  input logic rst_n_i,
  input logic ce_i,
  // serial line
  input logic rxd_i,
  output logic txd_o,
  // station address setting
  input logic st_wr_i,
  input logic [7:0] st_val_i,
  output logic [7:0] station_o
);
  localparam int IW = $clog2(GAP_FRAME_P + 1);
  localparam int RW = $clog2(RXB + 1);
  localparam logic [IW-1:0] GAP_C = IW'(GAP_CHAR_P);
  localparam logic [IW-1:0] GAP_F = IW'(GAP_FRAME_P);

  mbrs_state_t st_r, st_nxt;
  logic [7:0] station_r, station_nxt;
  logic [IW-1:0] idle_r, idle_nxt;
  logic [RXB-1:0][7:0] rbuf_r, rbuf_nxt;
  logic [RW-1:0] rcnt_r, rcnt_nxt;
  logic [15:0] rcrc_r, rcrc_nxt, tcrc_r, tcrc_nxt;
  logic [NREG-1:0][15:0] mem_r, mem_nxt;
  logic [7:0] fc_r, fc_nxt, exc_r, exc_nxt, k_r, k_nxt, rlen_r, rlen_nxt;
  logic [15:0] a_r, a_nxt, n_r, n_nxt;
  mbrs_byte_t rx;
  logic tx_vld, tx_rdy, len_ok, is_rd, rd_r, go_w;
  logic [7:0] tx_byte, kk, fc_w;
  logic [15:0] wa, wd, a_w, n_w;

  function automatic logic [15:0] rd_word(logic [15:0] a, logic [NREG-1:0][15:0] m);
    logic [15:0] w;
    w = UNDEF_VAL;
    for (int b = 0; b < NBLK; b++) begin
      if (a >= BLK_MAP[b].base && (a - BLK_MAP[b].base) < BLK_MAP[b].size) begin
        w = BLK_MAP[b].na ? BLK_MAP[b].fill : m[a[AW-1:0]];
      end
    end
    return w;
  endfunction

  // reads may span holes and whole blocks; writes must be one whole live block
  function automatic logic rng_ok(logic [15:0] a, logic [15:0] n, logic wr);
    logic [16:0] e, lo, hi;
    logic ok, hit;
    e = {1'b0, a} + {1'b0, n} - 17'h00001;
    ok = !e[16];
    hit = 1'b0;
    for (int b = 0; b < NBLK; b++) begin
      lo = {1'b0, BLK_MAP[b].base};
      hi = lo + {1'b0, BLK_MAP[b].size} - 17'h00001;
      if ({1'b0, a} > lo && {1'b0, a} <= hi) ok = 1'b0;
      if (e >= lo && e < hi) ok = 1'b0;
      if (a == BLK_MAP[b].base && n == BLK_MAP[b].size && !BLK_MAP[b].na) hit = 1'b1;
    end
    return wr ? hit : ok;
  endfunction

  mbrs_uart #(.BIT_CYC_P(BIT_CYC_P)) u_uart (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .rxd_i(rxd_i),
    .txd_o(txd_o),
    .rx_o(rx),
    .tx_vld_i(tx_vld),
    .tx_data_i(tx_byte),
    .tx_rdy_o(tx_rdy)
  );

  assign station_o = station_r;
  assign fc_w = rbuf_r[1];
  assign a_w = {rbuf_r[2], rbuf_r[3]};
  assign n_w = {rbuf_r[4], rbuf_r[5]};
  assign is_rd = (fc_w == FC_RD_HOLD) || (fc_w == FC_RD_IN);
  assign rd_r = (fc_r == FC_RD_HOLD) || (fc_r == FC_RD_IN);

  always_comb begin
    if (is_rd || fc_w == FC_WR_ONE) begin
      len_ok = (rcnt_r == RW'(8));
    end else if (fc_w == FC_WR_MANY) begin
      len_ok = (8'(rcnt_r) == rbuf_r[6] + 8'h09) && (rbuf_r[6] == {n_w[6:0], 1'b0}) && (n_w[15:7] == 9'h000);
    end else begin
      len_ok = 1'b1;
    end
    // an ascii frame fails the crc and is dropped
    go_w = (rcnt_r >= RW'(4)) && (rcrc_r == 16'h0000) && (rbuf_r[0] == station_r) && len_ok;
  end

  // station address and line idle timer
  always_comb begin
    station_nxt = station_r;
    if (st_wr_i && st_val_i >= ST_MIN && st_val_i <= ST_MAX) station_nxt = st_val_i;
    idle_nxt = '0;
    if (rxd_i) idle_nxt = (idle_r == GAP_F) ? idle_r : idle_r + 1'b1;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      station_r <= ST_RST;
      idle_r <= '0;
    end else if (ce_i) begin
      station_r <= station_nxt;
      idle_r <= idle_nxt;
    end
  end

  // answer bytes, big-endian words, crc low byte first
  always_comb begin
    kk = k_r - 8'h03;
    wa = (fc_r == FC_WR_ONE) ? a_r : a_r + {9'h000, kk[7:1]};
    wd = rd_word(wa, mem_r);
    if (k_r == rlen_r) tx_byte = tcrc_r[7:0];
    else if (k_r > rlen_r) tx_byte = tcrc_r[15:8];
    else if (k_r == 8'h00) tx_byte = station_r;
    else if (k_r == 8'h01) tx_byte = (exc_r != EX_NONE) ? (fc_r | FC_EXC) : fc_r;
    else if (exc_r != EX_NONE) tx_byte = exc_r;
    else if (rd_r && k_r == 8'h02) tx_byte = {n_r[6:0], 1'b0};
    else if (rd_r) tx_byte = kk[0] ? wd[7:0] : wd[15:8];
    else if (k_r == 8'h02) tx_byte = a_r[15:8];
    else if (k_r == 8'h03) tx_byte = a_r[7:0];
    else if (fc_r == FC_WR_ONE) tx_byte = (k_r == 8'h04) ? wd[15:8] : wd[7:0];
    else tx_byte = (k_r == 8'h04) ? n_r[15:8] : n_r[7:0];
  end

  always_comb begin
    st_nxt = st_r;
    rbuf_nxt = rbuf_r;
    rcnt_nxt = rcnt_r;
    rcrc_nxt = rcrc_r;
    tcrc_nxt = tcrc_r;
    mem_nxt = mem_r;
    fc_nxt = fc_r;
    exc_nxt = exc_r;
    k_nxt = k_r;
    rlen_nxt = rlen_r;
    a_nxt = a_r;
    n_nxt = n_r;
    tx_vld = 1'b0;
    case (st_r)
      S_RX: begin
        if (rx.vld && (rx.err || rcnt_r == RW'(RXB))) begin
          st_nxt = S_SYNC;
        end else if (rx.vld) begin
          rbuf_nxt[rcnt_r] = rx.data;
          rcnt_nxt = rcnt_r + 1'b1;
          rcrc_nxt = crc_step(rcrc_r, rx.data);
        end else if (rcnt_r != '0 && idle_r >= GAP_C) begin
          st_nxt = S_CHK;
        end
      end
      S_CHK: begin
        st_nxt = S_RX;
        rcnt_nxt = '0;
        rcrc_nxt = CRC_INIT;
        if (go_w) begin
          st_nxt = S_TX;
          fc_nxt = fc_w;
          a_nxt = a_w;
          n_nxt = n_w;
          k_nxt = 8'h00;
          tcrc_nxt = CRC_INIT;
          exc_nxt = EX_NONE;
          if (is_rd) begin
            if (n_w == 16'h0000 || n_w > MAX_RD) exc_nxt = EX_VAL;
            else if (!rng_ok(a_w, n_w, 1'b0)) exc_nxt = EX_ADDR;
          end else if (fc_w == FC_WR_ONE) begin
            if (!rng_ok(a_w, 16'h0001, 1'b1)) exc_nxt = EX_ADDR;
            else mem_nxt[a_w[AW-1:0]] = n_w;
          end else if (fc_w == FC_WR_MANY) begin
            if (!rng_ok(a_w, n_w, 1'b1)) begin
              exc_nxt = EX_ADDR;
            end else begin
              for (int i = 0; i < NREG; i++) begin
                if (i >= int'(a_w) && i < int'(a_w) + int'(n_w)) begin
                  mem_nxt[i] = {rbuf_r[7 + 2 * (i - int'(a_w))], rbuf_r[8 + 2 * (i - int'(a_w))]};
                end
              end
            end
          end else begin
            exc_nxt = EX_FUNC;
          end
          if (exc_nxt != EX_NONE) rlen_nxt = 8'h03;
          else if (is_rd) rlen_nxt = 8'({n_w[14:0], 1'b0} + 16'h0003);
          else rlen_nxt = 8'h06;
        end
      end
      S_TX: begin
        tx_vld = 1'b1;
        if (tx_rdy) begin
          k_nxt = k_r + 8'h01;
          if (k_r < rlen_r) tcrc_nxt = crc_step(tcrc_r, tx_byte);
          if (k_r == rlen_r + 8'h01) st_nxt = S_RX;
        end
      end
      S_SYNC: begin
        rcnt_nxt = '0;
        rcrc_nxt = CRC_INIT;
        if (idle_r == GAP_F) st_nxt = S_RX;
      end
      default: st_nxt = S_SYNC;
    endcase
  end

  // reset enters resync so a frame in flight at release is not half taken
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_r <= S_SYNC;
      rbuf_r <= '0;
      rcnt_r <= '0;
      rcrc_r <= CRC_INIT;
      tcrc_r <= CRC_INIT;
      mem_r <= {NREG{REG_RST}};
      fc_r <= 8'h00;
      exc_r <= EX_NONE;
      k_r <= 8'h00;
      rlen_r <= 8'h00;
      a_r <= 16'h0000;
      n_r <= 16'h0000;
    end else if (ce_i) begin
      st_r <= st_nxt;
      rbuf_r <= rbuf_nxt;
      rcnt_r <= rcnt_nxt;
      rcrc_r <= rcrc_nxt;
      tcrc_r <= tcrc_nxt;
      mem_r <= mem_nxt;
      fc_r <= fc_nxt;
      exc_r <= exc_nxt;
      k_r <= k_nxt;
      rlen_r <= rlen_nxt;
      a_r <= a_nxt;
      n_r <= n_nxt;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  st_range_a: assert property (station_r >= ST_MIN && station_r <= ST_MAX) else $error("bad station");
  st_reset_a: assert property ($rose(rst_n_i) |-> station_r == ST_RST) else $error("station not 1");
  gap_wait_a: assert property ($rose(st_r == S_CHK) |-> $past(idle_r) >= GAP_C) else $error("early end");
  resync_hold_a: assert property (st_r == S_SYNC && idle_r != GAP_F |=> st_r == S_SYNC) else $error("resync");
  rx_error_a: assert property (ce_i && st_r == S_RX && rx.vld && rx.err |=> st_r == S_SYNC) else $error("no resync");
  frame_drop_a: assert property (ce_i && st_r == S_CHK && (rcrc_r != 16'h0000 || rbuf_r[0] != station_r)
    |=> st_r == S_RX && rcnt_r == '0) else $error("bad frame answered");
  wr_block_a: assert property (ce_i && st_r == S_CHK && go_w && fc_w == FC_WR_MANY && !rng_ok(a_w, n_w, 1'b1)
    |=> exc_r == EX_ADDR && mem_r == $past(mem_r)) else $error("bad write taken");
  rd_block_a: assert property (ce_i && st_r == S_CHK && go_w && is_rd && n_w != 16'h0000 && n_w <= MAX_RD
    && !rng_ok(a_w, n_w, 1'b0) |=> st_r == S_TX && exc_r == EX_ADDR) else $error("split read taken");
  echo_value_a: assert property (ce_i && st_r == S_CHK && go_w && fc_w == FC_WR_ONE && rng_ok(a_w, 16'h0001, 1'b1)
    |=> exc_r == EX_NONE && rd_word(a_r, mem_r) == n_r && rlen_r == 8'h06) else $error("write not stored");
  tx_done_a: assert property (ce_i && st_r == S_TX && tx_rdy && k_r == rlen_r + 8'h01 |=> st_r == S_RX)
    else $error("answer not ended");

  read_ok_c: cover property (st_r == S_TX && rd_r && exc_r == EX_NONE && k_r == rlen_r);
  exc_addr_c: cover property (st_r == S_TX && exc_r == EX_ADDR);
  wr_many_c: cover property (st_r == S_TX && fc_r == FC_WR_MANY && exc_r == EX_NONE);
  resync_c: cover property (st_r == S_RX && rx.vld && rx.err);
endmodule

// ### src/mbrs_uart.sv
module mbrs_uart
  import mbrs_pkg::*;
#(
  parameter int BIT_CYC_P = BIT_CYC
) (
  // clock, reset, enable
  input logic core_clk_i,
  input logic rst_n_i,
  input logic ce_i,
  // serial line
  input logic rxd_i,
  output logic txd_o,
  // byte streams
  output mbrs_byte_t rx_o,
  input logic tx_vld_i,
  input logic [7:0] tx_data_i,
  output logic tx_rdy_o
);
  localparam int CW = $clog2(BIT_CYC_P);
  localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYC_P - 1);
  localparam logic [CW-1:0] BIT_HALF = CW'(BIT_CYC_P / 2);

  logic r_busy_r, r_busy_nxt, t_busy_r, t_busy_nxt, txd_nxt;
  logic [CW-1:0] r_cnt_r, r_cnt_nxt, t_cnt_r, t_cnt_nxt;
  logic [3:0] r_bit_r, r_bit_nxt, t_bit_r, t_bit_nxt;
  logic [7:0] r_sh_r, r_sh_nxt;
  logic [9:0] t_sh_r, t_sh_nxt;
  mbrs_byte_t rx_nxt;

  assign tx_rdy_o = !t_busy_r;

  // 8 data bits, no parity, one stop bit, lsb first
  always_comb begin
    r_busy_nxt = r_busy_r;
    r_cnt_nxt = r_cnt_r;
    r_bit_nxt = r_bit_r;
    r_sh_nxt = r_sh_r;
    rx_nxt = '0;
    if (!r_busy_r) begin
      if (!rxd_i) begin
        r_busy_nxt = 1'b1;
        r_cnt_nxt = BIT_HALF;
        r_bit_nxt = 4'h0;
      end
    end else if (r_cnt_r != '0) begin
      r_cnt_nxt = r_cnt_r - 1'b1;
    end else begin
      r_cnt_nxt = BIT_LAST;
      r_bit_nxt = r_bit_r + 4'h1;
      if (r_bit_r == 4'h0 && rxd_i) begin
        r_busy_nxt = 1'b0; // glitch, not a start bit
      end else if (r_bit_r == 4'h9) begin
        r_busy_nxt = 1'b0;
        rx_nxt = '{vld: 1'b1, err: !rxd_i, data: r_sh_r};
      end else if (r_bit_r != 4'h0) begin
        r_sh_nxt = {rxd_i, r_sh_r[7:1]};
      end
    end
    t_busy_nxt = t_busy_r;
    t_cnt_nxt = t_cnt_r;
    t_bit_nxt = t_bit_r;
    t_sh_nxt = t_sh_r;
    txd_nxt = txd_o;
    if (!t_busy_r) begin
      txd_nxt = 1'b1;
      if (tx_vld_i) begin
        t_busy_nxt = 1'b1;
        t_sh_nxt = {1'b1, tx_data_i, 1'b0};
        t_cnt_nxt = BIT_LAST;
        t_bit_nxt = 4'h0;
        txd_nxt = 1'b0;
      end
    end else if (t_cnt_r != '0) begin
      t_cnt_nxt = t_cnt_r - 1'b1;
    end else if (t_bit_r == 4'h9) begin
      t_busy_nxt = 1'b0;
    end else begin
      t_cnt_nxt = BIT_LAST;
      t_bit_nxt = t_bit_r + 4'h1;
      t_sh_nxt = {1'b1, t_sh_r[9:1]};
      txd_nxt = t_sh_r[1];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      r_busy_r <= 1'b0;
      r_cnt_r <= '0;
      r_bit_r <= 4'h0;
      r_sh_r <= 8'h00;
      rx_o <= '0;
      t_busy_r <= 1'b0;
      t_cnt_r <= '0;
      t_bit_r <= 4'h0;
      t_sh_r <= 10'h3ff;
      txd_o <= 1'b1;
    end else if (ce_i) begin
      r_busy_r <= r_busy_nxt;
      r_cnt_r <= r_cnt_nxt;
      r_bit_r <= r_bit_nxt;
      r_sh_r <= r_sh_nxt;
      rx_o <= rx_nxt;
      t_busy_r <= t_busy_nxt;
      t_cnt_r <= t_cnt_nxt;
      t_bit_r <= t_bit_nxt;
      t_sh_r <= t_sh_nxt;
      txd_o <= txd_nxt;
    end
  end

  tx_idle_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && tx_vld_i && tx_rdy_o |=> !txd_o && !tx_rdy_o) else $error("start bit not driven");
  tx_stop_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(tx_rdy_o) |-> txd_o && t_bit_r == 4'h9) else $error("frame ended without stop bit");
endmodule

// ### verification/mbrs_master.sv
module mbrs_master #(
  parameter int BIT_P = 8,
  parameter int END_P = 160
) (
  // clock
  input wire logic core_clk_i,
  // serial pair, idle high
  output logic line_o,
  input wire logic line_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rq [$];
  logic [7:0] frm [$];
  logic frm_ok;
  event rsp_ev;
  int idle_cnt = 0;
  int rx_idle = 0;

  initial line_o = 1'b1;

  function automatic logic [15:0] crc16(input logic [7:0] b [$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
    end
    return c;
  endfunction

  // a corrupted crc, a low stop bit or a mid-frame pause is sent only on request
  task automatic send(input logic [7:0] b [$], input int min_gap, input bit bad_crc, input int bad_stop,
                      input int gap_at, input int gap_len);
    logic [15:0] c;
    c = crc16(b) ^ {15'h0000, bad_crc};
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    while (idle_cnt < min_gap) @(negedge core_clk_i);
    foreach (b[i]) begin
      if (i == gap_at) repeat (gap_len) @(negedge core_clk_i);
      for (int k = 0; k < 10; k++) begin
        line_o = (k == 0) ? 1'b0 : ((k == 9) ? 1'(i != bad_stop) : b[i][k-1]);
        repeat (BIT_P) @(negedge core_clk_i);
      end
    end
  endtask

  always @(posedge core_clk_i) idle_cnt <= line_o ? idle_cnt + 1 : 0;

  initial begin
    logic [7:0] d;
    forever begin
      @(negedge line_i);
      repeat (BIT_P / 2) @(posedge core_clk_i);
      for (int k = 0; k < 8; k++) begin
        repeat (BIT_P) @(posedge core_clk_i);
        d[k] = line_i;
      end
      rq.push_back(d);
    end
  end

  // crc residue over a whole good frame is zero; the crc is stripped before handing on
  always @(posedge core_clk_i) begin
    rx_idle <= line_i ? rx_idle + 1 : 0;
    if (rx_idle == END_P && rq.size() > 2) begin
      frm_ok = (crc16(rq) == 16'h0000);
      frm = rq[0:rq.size() - 3];
      rq.delete();
      -> rsp_ev;
    end
  end
endmodule

// ### verification/tb_top.sv
module tb_top
  import mbrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] mbrs_bq_t [$];
  localparam int BITP = 8;
  localparam int GCP = 100;
  localparam int GFP = 200;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic rxd;
  logic txd;
  logic st_wr = 1'b0;
  logic [7:0] st_val = 8'h00;
  logic [7:0] station;
  logic [7:0] st = 8'h01;
  logic [15:0] shadow [8] = '{default: 16'h0000};
  mbrs_bq_t exp_q [$];
  int fails = 0;
  int total_checks = 0;
  int seed = 32'h46acaeae;
  int ra [12] = '{1, 0, 0, 0, 0, 4, 4, 7, 8, 6, 65535, 0};
  int rn [12] = '{2, 3, 5, 4, 6, 1, 2, 1, 2, 4, 2, 0};
  int wa [4] = '{0, 4, 7, 8};

  always #2.5 core_clk = ~core_clk;

  mbrs_slave #(.BIT_CYC_P(BITP), .GAP_CHAR_P(GCP), .GAP_FRAME_P(GFP)) mbrs_slave_inst (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .ce_i(ce), .rxd_i(rxd), .txd_o(txd),
    .st_wr_i(st_wr), .st_val_i(st_val), .station_o(station));
  mbrs_master #(.BIT_P(BITP), .END_P(20 * BITP)) mbrs_master_inst (
    .core_clk_i(core_clk), .line_o(rxd), .line_i(txd));

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    if (fails == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  function automatic mbrs_bq_t req6(input logic [7:0] fc, input int a, input int v);
    return {st, fc, 8'(a >> 8), 8'(a), 8'(v >> 8), 8'(v)};
  endfunction

  // undefined addresses read as all ones, the not-applicable register as its fill
  function automatic mbrs_bq_t exp_rd(input logic [7:0] fc, input int a, input int q);
    mbrs_bq_t r;
    logic [15:0] v;
    if (q == 0 || q > 125) return {st, fc | FC_EXC, EX_VAL};
    if (a + q > 65536 || a inside {1, 2, 3, 5} || (a + q) inside {1, 2, 3, 5}) return {st, fc | FC_EXC, EX_ADDR};
    r = {st, fc, 8'(2 * q)};
    for (int i = a; i < a + q; i++) begin
      v = (i < 7) ? shadow[i] : ((i == 7) ? BLK_MAP[3].fill : UNDEF_VAL);
      r.push_back(v[15:8]);
      r.push_back(v[7:0]);
    end
    return r;
  endfunction

  task automatic txn(input mbrs_bq_t req, input mbrs_bq_t rsp, input int gap = GFP, input bit bc = 0,
                     input int bs = -1, input int ga = -1, input int gl = 0, input int post = 400);
    int n;
    n = 0;
    if (rsp.size() != 0) exp_q.push_back(rsp);
    mbrs_master_inst.send(req, gap, bc, bs, ga, gl);
    while (exp_q.size() != 0 && n < 20000) begin
      @(negedge core_clk);
      n++;
    end
    if (exp_q.size() != 0) begin
      exp_q.delete();
      cmp8(8'h00, 8'h01);
    end
    repeat (post) @(negedge core_clk);
  endtask

  task automatic rdq(input logic [7:0] fc, input int a, input int q, input int ga = -1, input int gl = 0);
    txn(req6(fc, a, q), exp_rd(fc, a, q), GFP, 0, -1, ga, gl);
  endtask

  task automatic wr16(input int a, input logic [15:0] v [$]);
    mbrs_bq_t r;
    mbrs_bq_t e;
    int q;
    q = v.size();
    r = {st, FC_WR_MANY, 8'(a >> 8), 8'(a), 8'h00, 8'(q), 8'(2 * q)};
    foreach (v[i]) begin
      r.push_back(v[i][15:8]);
      r.push_back(v[i][7:0]);
    end
    e = {st, FC_WR_MANY | FC_EXC, EX_ADDR};
    if ((a == 0 && q == 4) || (a == 4 && q == 2) || (a == 6 && q == 1)) begin
      e = {st, FC_WR_MANY, 8'(a >> 8), 8'(a), 8'h00, 8'(q)};
      foreach (v[i]) shadow[a + i] = v[i];
    end
    txn(r, e);
  endtask

  task automatic wr6(input int a, input logic [15:0] v);
    mbrs_bq_t e;
    e = {st, FC_WR_ONE | FC_EXC, EX_ADDR};
    if (a == 6) begin
      e = req6(FC_WR_ONE, a, v);
      shadow[6] = v;
    end
    txn(req6(FC_WR_ONE, a, v), e);
  endtask

  // station register is written one cycle and read back two falling edges later
  task automatic set_st(input logic [7:0] v, input logic [7:0] exp);
    @(negedge core_clk);
    st_wr = 1'b1;
    st_val = v;
    @(negedge core_clk);
    st_wr = 1'b0;
    @(negedge core_clk);
    cmp8(station, exp);
  endtask

  // a response with no note left is compared against an empty note and so fails on length
  initial begin
    mbrs_bq_t e;
    forever begin
      @(mbrs_master_inst.rsp_ev);
      e = '{};
      if (exp_q.size() != 0) e = exp_q.pop_front();
      cmp8(8'(mbrs_master_inst.frm.size()), 8'(e.size()));
      cmp8({7'h00, mbrs_master_inst.frm_ok}, 8'h01);
      foreach (e[i]) begin
        if (i < mbrs_master_inst.frm.size()) cmp8(mbrs_master_inst.frm[i], e[i]);
      end
    end
  end

  initial begin
    // a clean run needs roughly 64k cycles; the margin stays under the 100k budget
    repeat (90000) @(posedge core_clk);
    fails++;
    $display("CHECK FAILED at %0t: got %h expected %h", $time, 8'h00, 8'h01);
    report_and_stop();
  end

  initial begin
    logic [7:0] v;
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    cmp8(station, ST_RST);
    repeat (GFP) @(negedge core_clk);
    wr6(6, 16'($random(seed)));
    rdq(FC_RD_HOLD, 6, 1);
    foreach (wa[i]) wr6(wa[i], 16'($random(seed)));
    wr16(4, {16'($random(seed)), 16'($random(seed))});
    wr16(0, {16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0006});
    wr16(1, {16'h0001, 16'h0002, 16'h0003});
    wr16(7, {16'h0007});
    wr16(8, {16'h0008});
    wr16(0, {16'h4869, 16'h2020, 16'h2020, 16'h2020});
    rdq(FC_RD_IN, 0, 6);
    for (int i = 0; i < 12; i++) rdq(i[0] ? FC_RD_IN : FC_RD_HOLD, ra[i], rn[i]);
    txn(req6(8'h05, 0, 1), {st, 8'h85, EX_FUNC});
    txn(req6(FC_RD_HOLD, 0, 4), '{}, GFP, 1);
    txn({8'h3a, 8'h30, 8'h31, 8'h30, 8'h33, 8'h30, 8'h30}, '{});
    rdq(FC_RD_HOLD, 0, 6, 4, 60);
    txn(req6(FC_RD_HOLD, 4, 2), '{}, GFP, 0, 2, -1, 0, 0);
    txn(req6(FC_RD_HOLD, 4, 2), '{}, GCP + 50, 0, -1, -1, 0, 0);
    rdq(FC_RD_HOLD, 4, 2);
    set_st(8'he0, 8'h01);
    set_st(8'hf7, 8'h01);
    set_st(8'h00, 8'h01);
    v = 8'(2 + ($unsigned($random(seed)) % 222));
    set_st(v, v);
    txn(req6(FC_RD_HOLD, 6, 1), '{});
    st = v;
    rdq(FC_RD_HOLD, 6, 1);
    // with the clock enable low a legal address strobe must leave the station frozen
    ce = 1'b0;
    set_st(v ^ 8'h01, v);
    ce = 1'b1;
    set_st(ST_MAX, ST_MAX);
    report_and_stop();
  end
endmodule
